// ---- include/fcws_pkg.sv ----
package fcws_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;

  // Command addresses and data
  localparam logic [18:0] UNLOCK1_ADDR = 19'h0_0555;
  localparam logic [18:0] UNLOCK2_ADDR = 19'h0_02AA;
  localparam logic [7:0]  UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
  localparam logic [7:0]  CMD_PROGRAM  = 8'hA0;
  localparam logic [7:0]  CMD_ERASE    = 8'h80;
  localparam logic [7:0]  CMD_CHIP_ER  = 8'h10;
  localparam logic [7:0]  CMD_SECT_ER  = 8'h30;
  localparam logic [7:0]  CMD_AUTOSEL  = 8'h90;
  localparam logic [7:0]  CMD_RESET    = 8'hF0;
  localparam logic [7:0]  CMD_SUSPEND  = 8'hB0;
  localparam logic [7:0]  CMD_RESUME   = 8'h30;

  // Status bit positions and sector address bits
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE1_BIT = 6;
  localparam int FAIL_BIT   = 5;
  localparam int TIMER_BIT  = 3;
  localparam int TOGGLE2_BIT = 2;
  localparam int SECT_HI    = 18;
  localparam int SECT_LO    = 16;

  // Host register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_WDATA  = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA  = 4'h4;
  localparam logic [3:0] REG_PROT   = 4'h5;

  // Operation codes written to REG_CTRL[3:0]
  localparam logic [3:0] OP_READ     = 4'h1;
  localparam logic [3:0] OP_PROGRAM  = 4'h2;
  localparam logic [3:0] OP_SECT_ER  = 4'h3;
  localparam logic [3:0] OP_CHIP_ER  = 4'h4;
  localparam logic [3:0] OP_SUSPEND  = 4'h5;
  localparam logic [3:0] OP_RESUME   = 4'h6;
  localparam logic [3:0] OP_RESET    = 4'h7;
  localparam logic [3:0] OP_AUTOSEL  = 4'h8;
  localparam logic [3:0] OP_ADD_SECT = 4'h9;

  // Bus cycle phases, 10 MHz clock
  localparam int CLK_NS      = 100;
  localparam int PHASE_NS    = 100;
  localparam int PHASE_CYC   = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] CYC_SETUP = 2'h0;
  localparam logic [1:0] CYC_PULSE = 2'h1;
  localparam logic [1:0] CYC_HOLD  = 2'h2;

  localparam logic [31:0] RESET_VAL = 32'h0000_0000;

  typedef enum logic [3:0] {
    FCWS_IDLE    = 4'b0000,
    FCWS_SEQ     = 4'b0001,
    FCWS_POLL1   = 4'b0010,
    FCWS_POLL2   = 4'b0011,
    FCWS_DONE    = 4'b0100,
    FCWS_FAIL    = 4'b0101
  } fcws_state_e;

endpackage

// ---- hw/fcws_bus_cycle.sv ----
`timescale 1ns/1ps
// One write or read bus cycle on the flash pins
module fcws_bus_cycle #(
  parameter int AW = 19,
  parameter int DW = 8
) (
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          start,
  input  wire logic          is_write,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic               done,
  output logic [DW-1:0]      rdata_q,
  output logic [AW-1:0]      flash_addr_q,
  output logic               flash_ce_n_q,
  output logic               flash_we_n_q,
  output logic               flash_oe_n_q,
  output logic [DW-1:0]      flash_dq_out_q,
  output logic               flash_dq_oe_q,
  input  wire logic [DW-1:0] flash_dq_in
);

  logic [1:0] phase_q;
  logic       busy_q;
  logic       wr_q;

  assign done = busy_q && (phase_q == fcws_pkg::CYC_HOLD);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_q  <= 1'b0;
      phase_q <= fcws_pkg::CYC_SETUP;
      wr_q    <= 1'b0;
    end
    else if (!busy_q)
    begin
      if (start)
      begin
        busy_q  <= 1'b1;
        phase_q <= fcws_pkg::CYC_SETUP;
        wr_q    <= is_write;
      end
    end
    else if (phase_q == fcws_pkg::CYC_HOLD)
      busy_q <= 1'b0;
    else
      phase_q <= phase_q + 2'h1;
  end

  // Address is set up before strobes fall; data held past strobe rise
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flash_addr_q   <= '0;
      flash_dq_out_q <= '0;
      flash_dq_oe_q  <= 1'b0;
      flash_ce_n_q   <= 1'b1;
      flash_we_n_q   <= 1'b1;
      flash_oe_n_q   <= 1'b1;
    end
    else if (!busy_q && start)
    begin
      flash_addr_q   <= addr;
      flash_dq_out_q <= wdata;
      flash_dq_oe_q  <= is_write;
      flash_ce_n_q   <= 1'b0;
    end
    else if (busy_q && phase_q == fcws_pkg::CYC_SETUP)
    begin
      flash_we_n_q <= !wr_q;
      flash_oe_n_q <= wr_q;
    end
    else if (busy_q && phase_q == fcws_pkg::CYC_PULSE)
    begin
      flash_we_n_q <= 1'b1;
      flash_oe_n_q <= 1'b1;
    end
    else if (busy_q && phase_q == fcws_pkg::CYC_HOLD)
    begin
      flash_ce_n_q  <= 1'b1;
      flash_dq_oe_q <= 1'b0;
    end
  end

  // Sample read data at end of the OE pulse
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= '0;
    else if (busy_q && phase_q == fcws_pkg::CYC_PULSE && !wr_q)
      rdata_q <= flash_dq_in;
  end

endmodule

// ---- hw/fcws_host.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Command cycles are all writes
// - Reset command leaves autoselect or failure
// - Autoselect fourth cycle is a read
// - Poll program at the programmed address
// - Poll erase inside a selected sector
// - Done when bit six reads the same twice in a row
// - Suspend B0, resume 30, any address
module fcws_host #(
  parameter int AW = fcws_pkg::ADDR_W,
  parameter int DW = fcws_pkg::DATA_W
) (
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic [3:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_write,
  input  wire logic          reg_read,
  output logic [31:0]        reg_rdata_q,
  output logic [AW-1:0]      flash_addr_q,
  output logic               flash_ce_n_q,
  output logic               flash_we_n_q,
  output logic               flash_oe_n_q,
  output logic [DW-1:0]      flash_dq_out_q,
  output logic               flash_dq_oe_q,
  input  wire logic [DW-1:0] flash_dq_in
);

  fcws_pkg::fcws_state_e state_q;

  logic [3:0]    op_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wdata_q;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] prev_q;
  logic [2:0]    step_q;
  logic [2:0]    nsteps;
  logic          busy_q;
  logic          fail_q;
  logic          timer_q;
  logic          protected_q;
  logic          suspended_q;
  logic          start;
  logic          is_write;
  logic [AW-1:0] cyc_addr;
  logic [DW-1:0] cyc_data;
  logic          cyc_done;
  logic [DW-1:0] cyc_rdata;
  logic          go;
  logic          cyc_busy_q;

  // Number of bus cycles per operation
  function automatic logic [2:0] op_len(input logic [3:0] op);
    case (op)
      fcws_pkg::OP_READ:     op_len = 3'd1;
      fcws_pkg::OP_PROGRAM:  op_len = 3'd4;
      fcws_pkg::OP_SECT_ER:  op_len = 3'd6;
      fcws_pkg::OP_CHIP_ER:  op_len = 3'd6;
      fcws_pkg::OP_SUSPEND:  op_len = 3'd1;
      fcws_pkg::OP_RESUME:   op_len = 3'd1;
      fcws_pkg::OP_RESET:    op_len = 3'd1;
      fcws_pkg::OP_AUTOSEL:  op_len = 3'd4;
      fcws_pkg::OP_ADD_SECT: op_len = 3'd1;
      default:               op_len = 3'd0;
    endcase
  endfunction

  function automatic logic op_polls(input logic [3:0] op);
    op_polls = (op == fcws_pkg::OP_PROGRAM) || (op == fcws_pkg::OP_SECT_ER) ||
               (op == fcws_pkg::OP_CHIP_ER);
  endfunction

  assign nsteps = op_len(op_q);
  assign go     = reg_write && (reg_addr == fcws_pkg::REG_CTRL) && !busy_q &&
                  (op_len(reg_wdata[3:0]) != 3'd0);

  // Sector address keeps A18..A16 only; low bits do not matter to the flash
  function automatic logic [AW-1:0] sect_addr(input logic [AW-1:0] a);
    sect_addr = '0;
    sect_addr[fcws_pkg::SECT_HI:fcws_pkg::SECT_LO] = a[fcws_pkg::SECT_HI:fcws_pkg::SECT_LO];
  endfunction

  // Pick the address and data of the current cycle
  always_comb
  begin
    cyc_addr = fcws_pkg::UNLOCK1_ADDR;
    cyc_data = fcws_pkg::UNLOCK1_DATA;
    is_write = 1'b1;
    if (state_q == fcws_pkg::FCWS_POLL1 || state_q == fcws_pkg::FCWS_POLL2)
    begin
      cyc_addr = addr_q;
      is_write = 1'b0;
    end
    else
    begin
      case (op_q)
        fcws_pkg::OP_READ:
        begin
          cyc_addr = addr_q;
          is_write = 1'b0;
        end
        fcws_pkg::OP_RESET:   cyc_data = fcws_pkg::CMD_RESET;
        fcws_pkg::OP_SUSPEND: cyc_data = fcws_pkg::CMD_SUSPEND;
        fcws_pkg::OP_RESUME:  cyc_data = fcws_pkg::CMD_RESUME;
        fcws_pkg::OP_ADD_SECT:
        begin
          cyc_addr = sect_addr(addr_q);
          cyc_data = fcws_pkg::CMD_SECT_ER;
        end
        default:
        begin
          case (step_q)
            3'd0: cyc_data = fcws_pkg::UNLOCK1_DATA;
            3'd1:
            begin
              cyc_addr = fcws_pkg::UNLOCK2_ADDR;
              cyc_data = fcws_pkg::UNLOCK2_DATA;
            end
            3'd2: cyc_data = (op_q == fcws_pkg::OP_PROGRAM) ? fcws_pkg::CMD_PROGRAM :
                             (op_q == fcws_pkg::OP_AUTOSEL) ? fcws_pkg::CMD_AUTOSEL :
                             fcws_pkg::CMD_ERASE;
            3'd3:
            begin
              if (op_q == fcws_pkg::OP_PROGRAM)
              begin
                cyc_addr = addr_q;
                cyc_data = wdata_q;
              end
              else if (op_q == fcws_pkg::OP_AUTOSEL)
              begin
                cyc_addr = addr_q;
                is_write = 1'b0;
              end
            end
            3'd4:
            begin
              cyc_addr = fcws_pkg::UNLOCK2_ADDR;
              cyc_data = fcws_pkg::UNLOCK2_DATA;
            end
            default:
            begin
              if (op_q == fcws_pkg::OP_SECT_ER)
              begin
                cyc_addr = sect_addr(addr_q);
                cyc_data = fcws_pkg::CMD_SECT_ER;
              end
              else
                cyc_data = fcws_pkg::CMD_CHIP_ER;
            end
          endcase
        end
      endcase
    end
  end

  assign start = busy_q && (state_q != fcws_pkg::FCWS_DONE) &&
                 (state_q != fcws_pkg::FCWS_FAIL) && !cyc_busy_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cyc_busy_q <= 1'b0;
    else if (cyc_done)
      cyc_busy_q <= 1'b0;
    else if (start)
      cyc_busy_q <= 1'b1;
  end

  fcws_bus_cycle #(
    .AW (AW),
    .DW (DW)
  ) u_cycle (
    .clock          (clock),
    .rst_n          (rst_n),
    .start          (start),
    .is_write       (is_write),
    .addr           (cyc_addr),
    .wdata          (cyc_data),
    .done           (cyc_done),
    .rdata_q        (cyc_rdata),
    .flash_addr_q   (flash_addr_q),
    .flash_ce_n_q   (flash_ce_n_q),
    .flash_we_n_q   (flash_we_n_q),
    .flash_oe_n_q   (flash_oe_n_q),
    .flash_dq_out_q (flash_dq_out_q),
    .flash_dq_oe_q  (flash_dq_oe_q),
    .flash_dq_in    (flash_dq_in)
  );

  // Sequencer; polling starts only after the last write strobe rose
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= fcws_pkg::FCWS_IDLE;
      step_q  <= 3'd0;
      busy_q  <= 1'b0;
    end
    else
    begin
      case (state_q)
        fcws_pkg::FCWS_IDLE:
        begin
          step_q <= 3'd0;
          if (go)
          begin
            busy_q  <= 1'b1;
            state_q <= fcws_pkg::FCWS_SEQ;
          end
        end
        fcws_pkg::FCWS_SEQ:
        begin
          if (cyc_done)
          begin
            if (step_q == nsteps - 3'd1)
              state_q <= op_polls(op_q) ? fcws_pkg::FCWS_POLL1 :
                         fcws_pkg::FCWS_DONE;
            else
              step_q <= step_q + 3'd1;
          end
        end
        fcws_pkg::FCWS_POLL1:
          if (cyc_done)
            state_q <= fcws_pkg::FCWS_POLL2;
        fcws_pkg::FCWS_POLL2:
        begin
          if (cyc_done)
          begin
            // Toggle bit unchanged across two reads means finished
            if (prev_q[fcws_pkg::TOGGLE1_BIT] == cyc_rdata[fcws_pkg::TOGGLE1_BIT])
              state_q <= fcws_pkg::FCWS_DONE;
            else if (cyc_rdata[fcws_pkg::FAIL_BIT] &&
                     prev_q[fcws_pkg::FAIL_BIT])
              state_q <= fcws_pkg::FCWS_FAIL;
            else
              state_q <= fcws_pkg::FCWS_POLL1;
          end
        end
        fcws_pkg::FCWS_DONE,
        fcws_pkg::FCWS_FAIL:
        begin
          busy_q  <= 1'b0;
          state_q <= fcws_pkg::FCWS_IDLE;
        end
        default: state_q <= fcws_pkg::FCWS_IDLE;
      endcase
    end
  end

  // Read results; after polling ends the next read is real data
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= '0;
      prev_q  <= '0;
    end
    else if (cyc_done && !is_write)
    begin
      prev_q  <= cyc_rdata;
      rdata_q <= cyc_rdata;
    end
  end

  // Status flags from read bytes, the fail state and finished suspend or resume
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fail_q      <= 1'b0;
      timer_q     <= 1'b0;
      protected_q <= 1'b0;
      suspended_q <= 1'b0;
    end
    else
    begin
      if (state_q == fcws_pkg::FCWS_FAIL)
        fail_q <= 1'b1;
      else if (go && reg_wdata[3:0] == fcws_pkg::OP_RESET)
        fail_q <= 1'b0;
      if (cyc_done && !is_write)
        timer_q <= cyc_rdata[fcws_pkg::TIMER_BIT];
      if (cyc_done && !is_write && op_q == fcws_pkg::OP_AUTOSEL)
        protected_q <= cyc_rdata[0];
      if (state_q == fcws_pkg::FCWS_DONE && op_q == fcws_pkg::OP_SUSPEND)
        suspended_q <= 1'b1;
      else if (state_q == fcws_pkg::FCWS_DONE && op_q == fcws_pkg::OP_RESUME)
        suspended_q <= 1'b0;
    end
  end

  // Host registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_q    <= 4'h0;
      addr_q  <= '0;
      wdata_q <= '0;
    end
    else if (reg_write)
    begin
      if (go)
        op_q <= reg_wdata[3:0];
      if (reg_addr == fcws_pkg::REG_ADDR && !busy_q)
        addr_q <= reg_wdata[AW-1:0];
      if (reg_addr == fcws_pkg::REG_WDATA && !busy_q)
        wdata_q <= reg_wdata[DW-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_q <= fcws_pkg::RESET_VAL;
    else if (reg_read)
    begin
      case (reg_addr)
        fcws_pkg::REG_CTRL:   reg_rdata_q <= {28'h000_0000, op_q};
        fcws_pkg::REG_ADDR:   reg_rdata_q <= {13'h0000, addr_q};
        fcws_pkg::REG_WDATA:  reg_rdata_q <= {24'h00_0000, wdata_q};
        fcws_pkg::REG_STATUS: reg_rdata_q <= {28'h000_0000, suspended_q, timer_q,
                                              fail_q, busy_q};
        fcws_pkg::REG_RDATA:  reg_rdata_q <= {24'h00_0000, rdata_q};
        fcws_pkg::REG_PROT:   reg_rdata_q <= {31'h0000_0000, protected_q};
        default:              reg_rdata_q <= fcws_pkg::RESET_VAL;
      endcase
    end
    else
      reg_rdata_q <= fcws_pkg::RESET_VAL;
  end

endmodule

// ---- bench/fcws_flash_model.sv ----
`timescale 1ns/1ps
module fcws_flash_model #(
  parameter int         BUSY = 4,
  parameter logic [7:0] PROT = 8'h04,
  parameter logic [7:0] ID   = 8'h5A  // Arbitrary identity value
) (
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [18:0] addr,
  input  wire logic [7:0]  dq_out,
  output logic [7:0]       dq_in
);
  logic [7:0]  mem [logic [18:0]];
  logic [18:0] la;
  logic [7:0]  tgt, esel, q, last;
  int          step, busy;
  bit          ers, susp, asel, fail, t1, t2;

  // Unwritten cells read as erased
  function automatic logic [7:0] rd(input logic [18:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  task automatic cmd(input logic [18:0] a, input logic [7:0] d);
    logic [2:0] s;
    s = a[18:16];
    if (fail || busy > 0 && !susp)
    begin
      if (d == 8'hF0 && fail)
        busy = 0;
      fail = fail && d != 8'hF0;
      susp = susp || d == 8'hB0 && ers;
    end
    else if (d == 8'hF0)
    begin
      step = 0;
      asel = 0;
    end
    else if (d == 8'h30 && susp && step == 0)
      susp = 0;
    else
      case (step)
        0, 3: step = (a[10:0] == 11'h555 && d == 8'hAA) ? step + 1 : 0;
        1, 4: step = (a[10:0] == 11'h2AA && d == 8'h55) ? step + 1 : 0;
        2:
        begin
          asel = asel || d == 8'h90;
          step = d == 8'hA0 ? 6 : d == 8'h80 ? 3 : 0;
        end
        5:
        begin
          esel = d == 8'h10 ? 8'hFF : 8'h01 << s;
          // Cells cleared at once; status hides them while busy
          foreach (mem[k])
            if (esel[k[18:16]] && !PROT[k[18:16]])
              mem[k] = 8'hFF;
          ers = 1;
          busy = BUSY;
          step = 0;
        end
        6:
        begin
          tgt = d;
          esel = 8'h00;
          ers = 0;
          busy = BUSY;
          step = 0;
          fail = !PROT[s] && (rd(a) & d) != d;
          if (!PROT[s] && !fail)
            mem[a] = d;
        end
        default: step = 0;
      endcase
  endtask

  initial
  begin
    step = 0;
    busy = 0;
    q = 8'h00;
    last = 8'h00;
    mem[19'h1_0010] = 8'h3C;
    mem[19'h2_0004] = 8'h77;
  end

  always @(negedge we_n or negedge ce_n)
    if (!we_n && !ce_n)
      la = addr;

  always @(posedge we_n or posedge ce_n)
    if (!(we_n && ce_n))
      cmd(la, dq_out);

  always @(negedge oe_n)
  begin
    if (asel)
      q = addr[7:0] == 8'h02 ? {7'h00, PROT[addr[18:16]]} : ID;
    else if (busy == 0 || susp && !esel[addr[18:16]])
      q = rd(addr);
    else
    begin
      t2 = t2 ^ esel[addr[18:16]];
      t1 = t1 ^ !susp;
      q = ers ? {susp, t1, fail, 1'b0, busy < BUSY, t2, 2'b00}
              : {~tgt[7], t1, fail, 5'h00};
      if (!susp && !fail)
        busy = busy - 1;
    end
  end

  // Released bus shows the inverse of the last byte
  always @(posedge oe_n)
    last = q;

  assign dq_in = (!ce_n && !oe_n) ? q : ~last;
endmodule

// ---- bench/fcws_host_checker.sv ----
`timescale 1ns/1ps
module fcws_host_checker #(
  parameter int AW = 19,
  parameter int DW = 8
) (
  input wire logic          clock,
  input wire logic          rst_n,
  input wire logic [3:0]    reg_addr,
  input wire logic [31:0]   reg_wdata,
  input wire logic          reg_write,
  input wire logic          reg_read,
  input wire logic [31:0]   reg_rdata_q,
  input wire logic [AW-1:0] flash_addr_q,
  input wire logic          flash_ce_n_q,
  input wire logic          flash_we_n_q,
  input wire logic          flash_oe_n_q,
  input wire logic [DW-1:0] flash_dq_out_q,
  input wire logic          flash_dq_oe_q,
  input wire logic [DW-1:0] flash_dq_in
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_WE_IN_CE: assert property (!flash_we_n_q |-> !flash_ce_n_q && !$past(flash_ce_n_q))
    else $error("Write strobe low without settled chip select");
  AST_WE_RISES_FIRST: assert property ($rose(flash_we_n_q) |->
    !flash_ce_n_q && flash_dq_oe_q && $stable(flash_dq_out_q))
    else $error("Write data or select not held at strobe rise");
  AST_ADDR_HELD: assert property ((!flash_we_n_q || !flash_oe_n_q) |-> $stable(flash_addr_q))
    else $error("Address moved during strobe");
  AST_WRITE_DRIVES: assert property (!flash_we_n_q |-> flash_dq_oe_q && flash_oe_n_q)
    else $error("Write cycle without driven bus");
  AST_READ_FLOATS: assert property (!flash_oe_n_q |-> !flash_dq_oe_q && !flash_ce_n_q)
    else $error("Read cycle with driven bus or no select");
  AST_STROBE_PULSE: assert property ($fell(flash_we_n_q) |=> $rose(flash_we_n_q))
    else $error("Write strobe not one cycle");
  AST_STROBE_AFTER_CE: assert property ($fell(flash_ce_n_q) |-> ##[1:2]
    (!flash_we_n_q || !flash_oe_n_q))
    else $error("No strobe after chip select");
  AST_CE_RELEASE: assert property (($rose(flash_oe_n_q) || $rose(flash_we_n_q))
    |=> $rose(flash_ce_n_q))
    else $error("Chip select not released after strobe");
  AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata_q == 32'h0000_0000)
    else $error("Read data outside read answer cycle");
endmodule

// ---- bench/tb_fcws_host.sv ----
`timescale 1ns/1ps
module tb_fcws_host;
  logic        clock, rst_n, reg_write, reg_read;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, v;
  logic [18:0] flash_addr_q;
  logic        flash_ce_n_q, flash_we_n_q, flash_oe_n_q, flash_dq_oe_q;
  logic [7:0]  flash_dq_out_q, flash_dq_in;
  int          n_fail, tests_run;

  fcws_host dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
    .flash_addr_q(flash_addr_q), .flash_ce_n_q(flash_ce_n_q), .flash_we_n_q(flash_we_n_q),
    .flash_oe_n_q(flash_oe_n_q), .flash_dq_out_q(flash_dq_out_q),
    .flash_dq_oe_q(flash_dq_oe_q), .flash_dq_in(flash_dq_in));
  fcws_flash_model partner (.ce_n(flash_ce_n_q), .we_n(flash_we_n_q), .oe_n(flash_oe_n_q),
    .addr(flash_addr_q), .dq_out(flash_dq_out_q), .dq_in(flash_dq_in));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata_q;
    @(posedge clock);
  endtask

  // Bounded poll so a stuck busy flag ends as a mismatch
  task automatic run_op(input logic [3:0] op, input logic [18:0] a);
    int i;
    wr(fcws_pkg::REG_ADDR, {13'h0000, a});
    wr(fcws_pkg::REG_CTRL, {28'h000_0000, op});
    v = 32'h0000_0001;
    for (i = 0; i < 500 && v[0] !== 1'b0; i++)
      rd(fcws_pkg::REG_STATUS, v);
    chk("busy", {31'h0000_0000, v[0]}, 32'h0000_0000);
  endtask

  task automatic fetch(input logic [18:0] a, input logic [7:0] e);
    run_op(fcws_pkg::OP_READ, a);
    rd(fcws_pkg::REG_RDATA, v);
    chk("read byte", {24'h00_0000, v[7:0]}, {24'h00_0000, e});
  endtask

  task automatic prog(input logic [18:0] a, input logic [7:0] d);
    wr(fcws_pkg::REG_WDATA, {24'h00_0000, d});
    run_op(fcws_pkg::OP_PROGRAM, a);
    rd(fcws_pkg::REG_STATUS, v);
  endtask

  task automatic t_program;
    fetch(19'h1_0010, 8'h3C);
    rd(4'hF, v);
    chk("unmapped", v, 32'h0000_0000);
    prog(19'h0_0100, 8'hA5);
    chk("fail flag", {31'h0000_0000, v[1]}, 32'h0000_0000);
    fetch(19'h0_0100, 8'hA5);
    prog(19'h2_0000, 8'h00);
    fetch(19'h2_0000, 8'hFF);
  endtask

  task automatic t_fail;
    prog(19'h0_0100, 8'hFF);
    chk("fail set", {31'h0000_0000, v[1]}, 32'h0000_0001);
    run_op(fcws_pkg::OP_RESET, 19'h0_0000);
    rd(fcws_pkg::REG_STATUS, v);
    chk("fail clear", {31'h0000_0000, v[1]}, 32'h0000_0000);
    fetch(19'h0_0100, 8'hA5);
  endtask

  task automatic t_erase;
    run_op(fcws_pkg::OP_SECT_ER, 19'h0_0000);
    rd(fcws_pkg::REG_STATUS, v);
    chk("timer", {31'h0000_0000, v[2]}, 32'h0000_0001);
    fetch(19'h0_0100, 8'hFF);
    fetch(19'h1_0010, 8'h3C);
    run_op(fcws_pkg::OP_SECT_ER, 19'h2_0000);
    fetch(19'h2_0004, 8'h77);
    run_op(fcws_pkg::OP_CHIP_ER, 19'h0_0000);
    fetch(19'h1_0010, 8'hFF);
    fetch(19'h2_0004, 8'h77);
  endtask

  task automatic t_autosel;
    run_op(fcws_pkg::OP_AUTOSEL, 19'h2_0002);
    rd(fcws_pkg::REG_PROT, v);
    chk("protected", {31'h0000_0000, v[0]}, 32'h0000_0001);
    run_op(fcws_pkg::OP_RESET, 19'h0_0000);
    run_op(fcws_pkg::OP_AUTOSEL, 19'h1_0002);
    rd(fcws_pkg::REG_PROT, v);
    chk("unprotected", {31'h0000_0000, v[0]}, 32'h0000_0000);
    run_op(fcws_pkg::OP_RESET, 19'h0_0000);
    fetch(19'h2_0004, 8'h77);
  endtask

  // Suspend, resume and added sector with no erase running
  task automatic t_idle_cmds;
    run_op(fcws_pkg::OP_SUSPEND, 19'h5_1234);
    rd(fcws_pkg::REG_STATUS, v);
    chk("suspended", {31'h0000_0000, v[3]}, 32'h0000_0001);
    run_op(fcws_pkg::OP_RESUME, 19'h3_0000);
    rd(fcws_pkg::REG_STATUS, v);
    chk("resumed", {31'h0000_0000, v[3]}, 32'h0000_0000);
    run_op(fcws_pkg::OP_ADD_SECT, 19'h2_0000);
    fetch(19'h2_0004, 8'h77);
  endtask

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial
  begin
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    n_fail = 0;
    tests_run = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_program;
    t_fail;
    t_erase;
    t_autosel;
    t_idle_cmds;
    close_out;
  end

  initial
  begin
    repeat (60000) @(posedge clock);
    n_fail++;
    close_out;
  end
endmodule

bind fcws_host fcws_host_checker #(.AW(AW), .DW(DW)) u_chk (.clock(clock), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata_q(reg_rdata_q), .flash_addr_q(flash_addr_q), .flash_ce_n_q(flash_ce_n_q),
  .flash_we_n_q(flash_we_n_q), .flash_oe_n_q(flash_oe_n_q),
  .flash_dq_out_q(flash_dq_out_q), .flash_dq_oe_q(flash_dq_oe_q), .flash_dq_in(flash_dq_in));
